// ---- core/sef_status.sv ----
/*
 * Error/event status register bank of the SPI MAC-PHY host interface.
 * Holds sticky W1C flags fed by event strobes from the SPI front end,
 * MAC and buffers; drives the active-low interrupt and footer status.
 * Assumes all strobes are one-cycle, synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sef_status
    import sef_pkg::*;
#(
    parameter logic CTRL_PROTECT_IMPL = 1'b1 // Control protection present
) (
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Mode and configuration
    input wire logic generic_mode,
    input wire logic ctrl_protect_en,
    input wire logic cut_through_en,
    input wire logic reset_done_mask,
    input wire logic phy_irq_mask,
    // Event sources
    input wire logic ctrl_write_corrupt,
    input wire logic crc_check_fail,
    input wire logic ts_slot_a_capture,
    input wire logic ts_slot_b_capture,
    input wire logic ts_slot_c_capture,
    input wire logic phy_irq_in,
    input wire logic header_parity_fail,
    input wire logic cs_early_release,
    input wire logic rx_buf_overflow,
    input wire logic tx_fifo_empty_read,
    input wire logic tx_fifo_full_write,
    // Transmit sequence
    input wire logic chunk_strobe,
    input wire logic chunk_data_valid,
    input wire logic chunk_start_valid,
    input wire logic chunk_end_valid,
    input wire logic size_write,
    input wire logic [sef_pkg::SIZE_W-1:0] tx_frame_size,
    input wire logic byte_write,
    // Outputs
    output logic irq_out_n,
    output logic footer_ext_status,
    output logic tx_abort,
    output logic tx_discard
);
    import sef_pkg::*;

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [12:0] set_vec; // Per-bit set events
    logic [12:0] clr_vec; // Per-bit W1C clears
    logic [12:0] flags; // Flag storage outputs
    logic status_wr; // Write hit on the status register
    logic ctrl_protect_err_set; // Qualified control protection event
    logic proto_err; // From sequence checker
    logic phy_irq_q; // Registered PHY summary
    logic phy_boot; // Summary forced after reset
    logic [31:0] next_rdata; // Read mux value

    assign status_wr = reg_wr && (reg_addr == STATUS_OFFSET);

    // -----------------------------------------------------------------
    // Event qualification
    // -----------------------------------------------------------------
    // Protection error only counts when the feature exists and is on
    assign ctrl_protect_err_set = CTRL_PROTECT_IMPL && ctrl_protect_en && !generic_mode && ctrl_write_corrupt;

    always_comb begin
        set_vec = '0;
        set_vec[CTRL_PROTECT_BIT] = ctrl_protect_err_set;
        set_vec[TX_CHECKSUM_BIT] = crc_check_fail;
        set_vec[TS_C_BIT] = ts_slot_c_capture;
        set_vec[TS_B_BIT] = ts_slot_b_capture;
        set_vec[TS_A_BIT] = ts_slot_a_capture;
        set_vec[HEADER_PARITY_BIT] = header_parity_fail && !generic_mode;
        set_vec[EARLY_CS_BIT] = cs_early_release || ctrl_protect_err_set;
        set_vec[RX_OVERFLOW_BIT] = rx_buf_overflow;
        set_vec[TX_UNDERRUN_BIT] = cut_through_en && tx_fifo_empty_read;
        set_vec[TX_OVERFLOW_BIT] = tx_fifo_full_write;
        set_vec[TX_PROTOCOL_BIT] = proto_err;
    end

    // Write one clears only W1C positions; zeros leave bits alone
    assign clr_vec = status_wr ? (reg_wdata[12:0] & W1C_MASK) : '0;

    // -----------------------------------------------------------------
    // Flag storage
    // -----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++) begin : g_flag
            if (gi == PHY_IRQ_BIT) begin : g_ro
                assign flags[gi] = phy_irq_q;
            end else if (gi == CTRL_PROTECT_BIT && !CTRL_PROTECT_IMPL) begin : g_rsvd
                assign flags[gi] = 1'b0;
            end else begin : g_w1c
                sef_flag #(
                    .RESET_VAL(STATUS_RESET[gi])
                ) u_flag (
                    .clk(clk),
                    .sys_rst(sys_rst),
                    .set(set_vec[gi]),
                    .clr(clr_vec[gi]),
                    .q(flags[gi])
                );
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // PHY summary: asserted on reset exit until the PHY source settles
    // -----------------------------------------------------------------
    // Held high from reset until phy_irq_in is first seen high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phy_boot <= 1'b1;
        end else if (phy_irq_in) begin
            phy_boot <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phy_irq_q <= 1'b0;
        end else begin
            phy_irq_q <= phy_irq_in || phy_boot;
        end
    end

    // -----------------------------------------------------------------
    // Interrupt and footer outputs
    // -----------------------------------------------------------------
    // Reset-done is non-maskable on the pin; PHY summary is masked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= !(flags[RESET_DONE_BIT] || (flags[PHY_IRQ_BIT] && !phy_irq_mask));
        end
    end

    // Footer extended status only while reset-done is unmasked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            footer_ext_status <= 1'b0;
        end else begin
            footer_ext_status <= flags[RESET_DONE_BIT] && !reset_done_mask;
        end
    end

    // Underrun stops the packet currently going out
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_abort <= 1'b0;
        end else begin
            tx_abort <= set_vec[TX_UNDERRUN_BIT];
        end
    end

    // -----------------------------------------------------------------
    // Transmit sequence checker and overflow discard
    // -----------------------------------------------------------------
    sef_seq u_seq (
        .clk(clk),
        .sys_rst(sys_rst),
        .generic_mode(generic_mode),
        .chunk_strobe(chunk_strobe),
        .chunk_data_valid(chunk_data_valid),
        .chunk_start_valid(chunk_start_valid),
        .chunk_end_valid(chunk_end_valid),
        .size_write(size_write),
        .tx_frame_size(tx_frame_size),
        .byte_write(byte_write),
        .fifo_overflow(tx_fifo_full_write),
        .proto_err(proto_err),
        .discard(tx_discard)
    );

    // -----------------------------------------------------------------
    // Read port: registered data, reserved bits zero
    // -----------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (reg_addr == STATUS_OFFSET) begin
            next_rdata[12:0] = flags;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_ctrl_protect_err_early_cs_release_err: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_protect_err_set |=> (flags[CTRL_PROTECT_BIT] && flags[EARLY_CS_BIT]))
        else $error("protection error without loss of frame");
    a_reset_done_boot: assert property (@(posedge clk)
        $fell(sys_rst) |-> flags[RESET_DONE_BIT])
        else $error("reset-done not set after reset");
    a_irq_non_mask: assert property (@(posedge clk) disable iff (sys_rst)
        flags[RESET_DONE_BIT] |=> !irq_out_n)
        else $error("reset-done did not drive irq");
    a_ext_status: assert property (@(posedge clk) disable iff (sys_rst)
        (flags[RESET_DONE_BIT] && !reset_done_mask) |=> footer_ext_status)
        else $error("footer extended status missing");
    a_underrun_gate: assert property (@(posedge clk) disable iff (sys_rst)
        (!cut_through_en && !flags[TX_UNDERRUN_BIT]) |=> !flags[TX_UNDERRUN_BIT] || $past(cut_through_en))
        else $error("underrun set without cut-through");
    a_phy_boot: assert property (@(posedge clk)
        $fell(sys_rst) |=> flags[PHY_IRQ_BIT])
        else $error("phy summary not asserted after reset");
    a_hdr_parity: assert property (@(posedge clk) disable iff (sys_rst)
        (header_parity_fail && !generic_mode) |=> flags[HEADER_PARITY_BIT])
        else $error("header parity not flagged");
    a_wr_zero_keeps: assert property (@(posedge clk) disable iff (sys_rst)
        (status_wr && reg_wdata[RX_OVERFLOW_BIT] == 1'b0 && flags[RX_OVERFLOW_BIT]) |=> flags[RX_OVERFLOW_BIT])
        else $error("write zero cleared a flag");
    a_rx_ovf_set: assert property (@(posedge clk) disable iff (sys_rst)
        rx_buf_overflow |=> flags[RX_OVERFLOW_BIT])
        else $error("rx overflow not flagged");
endmodule // sef_status
`default_nettype wire

// ---- core/sef_pkg.sv ----
/*
 * Constants for the error/event status register bank: offset, bit
 * positions, reset value, clear mask and detector states.
 * Assumes a single 100 MHz clock and a synchronous active-high reset.
 */
// How it works
// - Corrupted protected control write sets bit 12
// - Without protection, bit 12 reads zero
// - Bad FCS sets bit 11, frame still sent
// - Three W1C timestamp slot flags, C10 B9
// - Read-only bit 7 mirrors PHY interrupt
// - PHY summary asserted after reset, masked
// - Reset-done bit 6 resets one, drives irq
// - Footer extended status while reset-done unmasked
// - Header parity failure sets bit 5
// - Early chip-select release sets bit 4
// - Control protection error also sets bit 4
// - Receive buffer overflow sets bit 3
// - Underrun only with cut-through, stops packet
// - Overflow drops frame until next start
// - Chunk protocol start/data sequence errors set bit 0
// - Early frame size write sets bit 0
// - CRC32 checked during transmission, error flagged
package sef_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] STATUS_OFFSET = 8'h08; // Word address
    localparam logic [31:0] STATUS_RESET = 32'h0000_0040; // After reset
    localparam int CTRL_PROTECT_BIT = 12;
    localparam int TX_CHECKSUM_BIT = 11;
    localparam int TS_C_BIT = 10;
    localparam int TS_B_BIT = 9;
    localparam int TS_A_BIT = 8; // Slot A position not printed cleanly
    localparam int PHY_IRQ_BIT = 7;
    localparam int RESET_DONE_BIT = 6;
    localparam int HEADER_PARITY_BIT = 5;
    localparam int EARLY_CS_BIT = 4;
    localparam int RX_OVERFLOW_BIT = 3;
    localparam int TX_UNDERRUN_BIT = 2;
    localparam int TX_OVERFLOW_BIT = 1;
    localparam int TX_PROTOCOL_BIT = 0;
    localparam logic [12:0] W1C_MASK = 13'h1f7f; // All but bit 7
    // -----------------------------------------------------------------
    // Transmit FIFO size in bytes and the frame size counter width
    // -----------------------------------------------------------------
    localparam int TX_FIFO_BYTES = 4096; // Room for more than one frame
    localparam int SIZE_W = 16;
    // -----------------------------------------------------------------
    // Chunk sequence states
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEF_IDLE = 2'b01,
        SEF_IN_FRAME = 2'b10
    } sef_chunk_state_t;
endpackage : sef_pkg

// ---- core/sef_flag.sv ----
/*
 * One sticky write-one-to-clear flag.
 * Assumes set and clear are single-cycle qualified strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module sef_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    // -----------------------------------------------------------------
    // Sticky bit: set wins so no event is lost
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= RESET_VAL;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

    a_set_beats_clr: assert property (@(posedge clk) disable iff (sys_rst) set |=> q)
        else $error("flag lost on set");
endmodule // sef_flag
`default_nettype wire

// ---- core/sef_seq.sv ----
/*
 * Transmit sequence checker: chunk start/data/end ordering and generic
 * frame-size bookkeeping, plus overflow discard until next frame start.
 * Assumes strobes are one-cycle pulses from the SPI front end.
 */
`timescale 1ns/1ps
`default_nettype none
module sef_seq
    import sef_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic generic_mode,
    input wire logic chunk_strobe,
    input wire logic chunk_data_valid,
    input wire logic chunk_start_valid,
    input wire logic chunk_end_valid,
    input wire logic size_write,
    input wire logic [sef_pkg::SIZE_W-1:0] tx_frame_size,
    input wire logic byte_write,
    input wire logic fifo_overflow,
    output logic proto_err,
    output logic discard
);
    import sef_pkg::*;
    sef_chunk_state_t state; // Chunk frame tracking
    logic [SIZE_W-1:0] remain; // Bytes still owed in generic mode
    logic sof; // Start of frame seen this cycle

    assign sof = generic_mode ? size_write : (chunk_strobe && chunk_start_valid);

    // -----------------------------------------------------------------
    // Protocol error detection
    // -----------------------------------------------------------------
    always_comb begin
        proto_err = 1'b0;
        if (!generic_mode && chunk_strobe && chunk_data_valid) begin
            case (state)
                SEF_IDLE: proto_err = !chunk_start_valid;
                SEF_IN_FRAME: proto_err = chunk_start_valid;
                default: proto_err = 1'b0;
            endcase
        end else if (generic_mode && size_write) begin
            proto_err = (remain != '0);
        end
    end

    // -----------------------------------------------------------------
    // Chunk state: open on start, close on end
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= SEF_IDLE;
        end else if (!generic_mode && chunk_strobe && chunk_data_valid) begin
            case (state)
                SEF_IDLE: state <= (chunk_start_valid && !chunk_end_valid) ? SEF_IN_FRAME : SEF_IDLE;
                SEF_IN_FRAME: state <= chunk_end_valid ? SEF_IDLE : SEF_IN_FRAME;
                default: state <= SEF_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Generic mode: count bytes owed against announced size
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remain <= '0;
        end else if (size_write) begin
            remain <= tx_frame_size;
        end else if (byte_write && remain != '0) begin
            remain <= remain - SIZE_W'(1);
        end
    end

    // -----------------------------------------------------------------
    // Overflow discards rest of frame; writes resume at next start
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            discard <= 1'b0;
        end else if (sof) begin
            discard <= 1'b0;
        end else if (fifo_overflow) begin
            discard <= 1'b1;
        end
    end

    a_dup_start_err: assert property (@(posedge clk) disable iff (sys_rst)
        (!generic_mode && chunk_strobe && chunk_data_valid && chunk_start_valid && state == SEF_IN_FRAME)
        |-> proto_err)
        else $error("repeated start not flagged");
    a_discard_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (fifo_overflow && !sof) |=> discard)
        else $error("overflow did not discard");
endmodule // sef_seq
`default_nettype wire

// ---- verification/sef_host_model.sv ----
/*
 * Host-side frame writer for the generic protocol: announces a frame
 * size, then writes its bytes back to back.
 * Assumes send_frame is called from the bench at a falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sef_host_model
    import sef_pkg::*;
#(
    parameter int FREE_BYTES = 4096 // Space the host believes is free
) (
    input wire logic clk,
    output logic size_write,
    output logic [sef_pkg::SIZE_W-1:0] tx_frame_size,
    output logic byte_write
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        size_write = 1'b0;
        tx_frame_size = '0;
        byte_write = 1'b0;
    end

    // Size write, then nbytes writes with no gaps between them; nothing is driven if nbytes exceeds FREE_BYTES
    task automatic send_frame(input logic [SIZE_W-1:0] size, input int nbytes);
        if (nbytes <= FREE_BYTES) begin
            @(negedge clk);
            size_write = 1'b1;
            tx_frame_size = size;
            @(negedge clk);
            size_write = 1'b0;
            tx_frame_size = ~size; // Stale value no longer valid
            for (int i = 0; i < nbytes; i++) begin
                byte_write = 1'b1; // Faster than line rate
                @(negedge clk);
            end
            byte_write = 1'b0;
        end
    endtask
endmodule // sef_host_model
`default_nettype wire

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench for the error/event status bank.
 * Assumes a 100 MHz clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sef_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic generic_mode = 1'b0, ctrl_protect_en = 1'b1, cut_through_en = 1'b1;
    logic reset_done_mask = 1'b0, phy_irq_mask = 1'b1, phy_irq_in = 1'b0;
    logic [9:0] ev = 10'h000; // One bit per event strobe
    logic chunk_strobe = 1'b0, chunk_data_valid = 1'b0;
    logic chunk_start_valid = 1'b0, chunk_end_valid = 1'b0;
    logic size_write, byte_write;
    logic [SIZE_W-1:0] tx_frame_size;
    logic irq_out_n, footer_ext_status, tx_abort, tx_discard;
    logic [31:0] rdata_noprot; // Read data of the copy built without protection
    int bad_count = 0, n_tests = 0, abort_cnt = 0;

    // Free-running clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end

    // Abort is a single-cycle pulse, so count it on every rising edge
    always @(posedge clk) begin
        if (tx_abort === 1'b1) begin
            abort_cnt <= abort_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Design and far-side host
    // ------------------------------------------------------------
    sef_status dut (
        .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .generic_mode(generic_mode),
        .ctrl_protect_en(ctrl_protect_en), .cut_through_en(cut_through_en),
        .reset_done_mask(reset_done_mask), .phy_irq_mask(phy_irq_mask),
        .ctrl_write_corrupt(ev[0]), .crc_check_fail(ev[1]), .ts_slot_a_capture(ev[2]),
        .ts_slot_b_capture(ev[3]), .ts_slot_c_capture(ev[4]), .phy_irq_in(phy_irq_in),
        .header_parity_fail(ev[5]), .cs_early_release(ev[6]), .rx_buf_overflow(ev[7]),
        .tx_fifo_empty_read(ev[8]), .tx_fifo_full_write(ev[9]), .chunk_strobe(chunk_strobe),
        .chunk_data_valid(chunk_data_valid), .chunk_start_valid(chunk_start_valid),
        .chunk_end_valid(chunk_end_valid), .size_write(size_write), .tx_frame_size(tx_frame_size),
        .byte_write(byte_write), .irq_out_n(irq_out_n), .footer_ext_status(footer_ext_status),
        .tx_abort(tx_abort), .tx_discard(tx_discard)
    );
    // Copy without control protection, fed the same stimulus
    sef_status #(
        .CTRL_PROTECT_IMPL(1'b0)
    ) dut_noprot (
        .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata_noprot), .generic_mode(generic_mode),
        .ctrl_protect_en(ctrl_protect_en), .cut_through_en(cut_through_en),
        .reset_done_mask(reset_done_mask), .phy_irq_mask(phy_irq_mask),
        .ctrl_write_corrupt(ev[0]), .crc_check_fail(ev[1]), .ts_slot_a_capture(ev[2]),
        .ts_slot_b_capture(ev[3]), .ts_slot_c_capture(ev[4]), .phy_irq_in(phy_irq_in),
        .header_parity_fail(ev[5]), .cs_early_release(ev[6]), .rx_buf_overflow(ev[7]),
        .tx_fifo_empty_read(ev[8]), .tx_fifo_full_write(ev[9]), .chunk_strobe(chunk_strobe),
        .chunk_data_valid(chunk_data_valid), .chunk_start_valid(chunk_start_valid),
        .chunk_end_valid(chunk_end_valid), .size_write(size_write), .tx_frame_size(tx_frame_size),
        .byte_write(byte_write), .irq_out_n(), .footer_ext_status(),
        .tx_abort(), .tx_discard()
    );
    sef_host_model u_host (
        .clk(clk), .size_write(size_write), .tx_frame_size(tx_frame_size), .byte_write(byte_write)
    );

    // ------------------------------------------------------------
    // Compare, access and stimulus tasks
    // ------------------------------------------------------------
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read strobe for one edge; data is registered on that edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        check32(reg_rdata, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic pulse(input int i);
        @(negedge clk);
        ev[i] = 1'b1;
        @(negedge clk);
        ev[i] = 1'b0;
    endtask

    task automatic chunk(input logic d, input logic s, input logic e);
        @(negedge clk);
        chunk_strobe = 1'b1;
        chunk_data_valid = d;
        chunk_start_valid = s;
        chunk_end_valid = e;
        @(negedge clk);
        chunk_strobe = 1'b0;
    endtask

    // Flag pattern each event strobe should leave behind
    function automatic logic [31:0] exp_bits(input int i);
        case (i)
            0: exp_bits = (32'h1 << CTRL_PROTECT_BIT) | (32'h1 << EARLY_CS_BIT);
            1: exp_bits = 32'h1 << TX_CHECKSUM_BIT;
            2: exp_bits = 32'h1 << TS_A_BIT;
            3: exp_bits = 32'h1 << TS_B_BIT;
            4: exp_bits = 32'h1 << TS_C_BIT;
            5: exp_bits = 32'h1 << HEADER_PARITY_BIT;
            6: exp_bits = 32'h1 << EARLY_CS_BIT;
            7: exp_bits = 32'h1 << RX_OVERFLOW_BIT;
            8: exp_bits = 32'h1 << TX_UNDERRUN_BIT;
            default: exp_bits = 32'h1 << TX_OVERFLOW_BIT;
        endcase
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles of the tests
    initial begin
        #100000;
        bad_count++;
        $display("watchdog expired at %0t", $time);
        summarize();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h08, 32'h0000_00c0);
        check1(irq_out_n, 1'b0);
        check1(footer_ext_status, 1'b1);
        reset_done_mask = 1'b1;
        repeat (3) @(negedge clk);
        check1(footer_ext_status, 1'b0);
        wr(8'h08, 32'hffff_ffbf);
        rd(8'h08, 32'h0000_00c0);
        wr(8'h0c, 32'h0000_0040);
        rd(8'h0c, 32'h0000_0000);
        rd(8'h08, 32'h0000_00c0);
        wr(8'h08, 32'h0000_0040);
        rd(8'h08, 32'h0000_0080);
        check1(irq_out_n, 1'b1);
        $display("test reset state done");
        // PHY summary follows its source and ignores writes
        phy_irq_mask = 1'b0;
        phy_irq_in = 1'b1;
        wr(8'h08, 32'h0000_0080);
        rd(8'h08, 32'h0000_0080);
        check1(irq_out_n, 1'b0);
        phy_irq_in = 1'b0;
        rd(8'h08, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        check1(irq_out_n, 1'b1);
        $display("test phy summary done");
        // Every event: set, survive a zero write, clear by one
        for (int i = 0; i < 10; i++) begin
            pulse(i);
            rd(8'h08, exp_bits(i));
            if (i == 0) begin
                check32(rdata_noprot, 32'h0);
            end
            wr(8'h08, 32'h0);
            rd(8'h08, exp_bits(i));
            wr(8'h08, exp_bits(i));
            rd(8'h08, 32'h0);
        end
        check32(32'(abort_cnt), 32'h1);
        check1(tx_discard, 1'b1);
        $display("test event flags done");
        // Unqualified events are ignored
        generic_mode = 1'b1;
        cut_through_en = 1'b0;
        pulse(0);
        pulse(5);
        pulse(8);
        rd(8'h08, 32'h0);
        check32(32'(abort_cnt), 32'h1);
        // Set and clear in the same cycle
        fork
            pulse(6);
            wr(8'h08, 32'h0000_0010);
        join
        rd(8'h08, 32'h0000_0010);
        wr(8'h08, 32'h0000_0010);
        $display("test refusals done");
        // Generic protocol: complete frame, then a short one
        u_host.send_frame(16'h0004, 4);
        check1(tx_discard, 1'b0);
        rd(8'h08, 32'h0);
        u_host.send_frame(16'h0004, 2);
        u_host.send_frame(16'h0004, 4);
        rd(8'h08, 32'h0000_0001);
        wr(8'h08, 32'h0000_0001);
        $display("test generic sequence done");
        // Chunk protocol ordering
        generic_mode = 1'b0;
        chunk(1'b1, 1'b0, 1'b0);
        rd(8'h08, 32'h0000_0001);
        wr(8'h08, 32'h0000_0001);
        chunk(1'b1, 1'b1, 1'b0);
        chunk(1'b1, 1'b0, 1'b0);
        chunk(1'b1, 1'b0, 1'b1);
        rd(8'h08, 32'h0);
        chunk(1'b1, 1'b1, 1'b0);
        chunk(1'b1, 1'b1, 1'b0);
        rd(8'h08, 32'h0000_0001);
        $display("test chunk sequence done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
